//--- clkout_regs.svh
// Purpose: offsets, fields, reset values and timing counts for the clock output block
// Assumes: apb with 32-bit data, one word per register
// Notes: included by bare name
`ifndef CLKOUT_REGS_SVH
`define CLKOUT_REGS_SVH
`define NPORTS 20
`define OFF_CTRL 12'h000
`define OFF_PORT_EN 12'h004
`define OFF_PORT_FAULT 12'h008
`define OFF_PORT_STATE 12'h00c
`define OFF_INT_STAT 12'h010
`define OFF_INT_MASK 12'h014
`define OFF_QL 12'h018
`define OFF_SQ_BASE 12'h020
`define OFF_LED 12'h040
// ctrl fields
`define CTRL_DISABLE 0
`define CTRL_DOWNLOAD 1
`define CTRL_FAIL 2
`define CTRL_REDUNDANT 3
`define CTRL_ISOLATE 4
`define CTRL_BYPASS_IGN 5
`define CTRL_EXP_IGN 6
`define CTRL_RESET 32'h0000_0000
`define PORT_EN_RESET 20'hf_ffff
// interrupt bits
`define INT_PORT_FAULT 0
`define INT_REF_CHANGE 1
`define INT_SQUELCH 2
// blink half period of 250 ms at 100 MHz, in cycles
`define BLINK_MS 250
`define CLK_MHZ 100
`define BLINK_CYCLES (`BLINK_MS * 1000 * `CLK_MHZ)
`endif

//--- clkout_pkg.sv
// Purpose: types for the clock output block
// Assumes: none
// Notes: led encoding and reference index
package clkout_pkg;
  typedef enum logic [1:0] {led_off_type_v = 2'h0, led_green = 2'h1, led_amber = 2'h2} led_type;
  typedef enum logic [1:0] {ref_a = 2'h0, ref_b = 2'h1, ref_c = 2'h2, ref_d = 2'h3} ref_sel_type;
endpackage

//--- clock_output_status_ctrl.sv
// Purpose: status indicators, per-port relay and squelch control, 2048 kHz derivation
// Assumes: pll_clk_i is the 8.192 MHz locked signal brought in as a level and sampled
// Notes: pll itself and level detectors are external; pll_ref_sel drives the pll mux
// Functional notes
// - status led green when good, blinking disabled or download, amber on failure.
// - reference a led green selected, amber faulty or missing, else dark.
// - reference b led green selected, amber faulty or missing, else dark.
// - bypass led green selected, amber faulty, dark when ignored or unselected.
// - expansion led green selected, amber faulty, dark when ignored, unselected or outside an expansion shelf.
// - output fault led amber while any port flagged faulty.
// - accept three or four 4 kHz references; steer pll to selected one, or to reference a when d is selected outside an expansion shelf.
// - twenty 2048 kHz outputs, each on its own tip and ring pair.
// - each port enabled independently; relay opens when disabled.
// - port marked failed when its level detector reports low amplitude.
// - non-redundant mode keeps failed port enabled, still flagged.
// - redundant mode switches off failed ports only in the isolating module.
// - squelch threshold zero disables; nonzero squelches when quality level exceeds.
`timescale 1ns/100ps
`default_nettype none
`include "clkout_regs.svh"
module clock_output_status_ctrl
  import clkout_pkg::*;
#(
  parameter int NP = `NPORTS,
  parameter int BLINK_CYCLES = `BLINK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ref_present,
  input wire logic [3:0] ref_good,
  input wire logic [1:0] ref_selected,
  input wire logic expansion_shelf,
  input wire logic pll_clk_i,
  input wire logic [NP-1:0] level_low,
  output logic [1:0] pll_ref_sel,
  output logic [NP-1:0] output_tip_line,
  output logic [NP-1:0] output_ring_line,
  output logic [NP-1:0] relay_closed,
  output logic [1:0] led_status,
  output logic [1:0] led_ref_a,
  output logic [1:0] led_ref_b,
  output logic [1:0] led_ref_c,
  output logic [1:0] led_ref_d,
  output logic led_out_fault,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: pins are asynchronous to pclk
  logic [3:0] pres_s1_r, pres_r, good_s1_r, good_r;
  logic [1:0] sel_s1_r, sel_r;
  logic exp_s1_r, exp_r, pll_s1_r, pll_r, pll_d_r;
  logic [NP-1:0] low_s1_r, low_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pres_s1_r <= 4'h0;
      pres_r <= 4'h0;
      good_s1_r <= 4'h0;
      good_r <= 4'h0;
      sel_s1_r <= 2'h0;
      sel_r <= 2'h0;
      exp_s1_r <= 1'b0;
      exp_r <= 1'b0;
      pll_s1_r <= 1'b0;
      pll_r <= 1'b0;
      pll_d_r <= 1'b0;
      low_s1_r <= '0;
      low_r <= '0;
    end else begin
      pres_s1_r <= ref_present;
      pres_r <= pres_s1_r;
      good_s1_r <= ref_good;
      good_r <= good_s1_r;
      sel_s1_r <= ref_selected;
      sel_r <= sel_s1_r;
      exp_s1_r <= expansion_shelf;
      exp_r <= exp_s1_r;
      pll_s1_r <= pll_clk_i;
      pll_r <= pll_s1_r;
      pll_d_r <= pll_r;
      low_s1_r <= level_low;
      low_r <= low_s1_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [NP-1:0] en_r, en_nxt, flt_r, flt_nxt, drive_r, drive_nxt;
  logic [2:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
  logic [3:0] ql_r, ql_nxt;
  logic [3:0] sq_r [NP], sq_nxt [NP];
  logic [31:0] prdata_nxt;
  logic [NP-1:0] sq_hit;
  logic [1:0] div_r, div_nxt;
  logic [1:0] last_sel_r;
  logic [NP-1:0] last_sq_r;
  logic wr, rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      sq_hit[i] = (sq_r[i] != 4'h0) && (ql_r > sq_r[i]);
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    en_nxt = en_r;
    ql_nxt = ql_r;
    imsk_nxt = imsk_r;
    ist_nxt = ist_r;
    for (int i = 0; i < NP; i++) begin
      sq_nxt[i] = sq_r[i];
    end
    if (wr) begin
      case (paddr)
        `OFF_CTRL: ctrl_nxt = pwdata;
        `OFF_PORT_EN: en_nxt = pwdata[NP-1:0];
        `OFF_QL: ql_nxt = pwdata[3:0];
        `OFF_INT_MASK: imsk_nxt = pwdata[2:0];
        `OFF_INT_STAT: ist_nxt = ist_r & ~pwdata[2:0];
        default: begin
          for (int i = 0; i < NP; i++) begin
            if (paddr == `OFF_SQ_BASE + 12'(i / 8 * 4) && ((i % 8) == 0)) begin
              for (int j = 0; j < 8 && i + j < NP; j++) begin
                sq_nxt[i+j] = pwdata[j*4 +: 4];
              end
            end
          end
        end
      endcase
    end
    // set wins over write-one clear
    if ((flt_nxt & ~flt_r) != '0) ist_nxt[`INT_PORT_FAULT] = 1'b1;
    if (sel_r != last_sel_r) ist_nxt[`INT_REF_CHANGE] = 1'b1;
    if ((sq_hit & ~last_sq_r) != '0) ist_nxt[`INT_SQUELCH] = 1'b1;
  end

  // per-port fault flag follows level detector
  // redundant drops failed ports only when this module isolates
  always_comb begin
    flt_nxt = low_r;
    for (int i = 0; i < NP; i++) begin
      drive_nxt[i] = en_r[i] && !sq_hit[i] &&
        !(ctrl_r[`CTRL_REDUNDANT] && ctrl_r[`CTRL_ISOLATE] && flt_r[i]);
    end
  end

  // divide by four on pll rising edges
  always_comb begin
    div_nxt = div_r;
    if (pll_r && !pll_d_r) div_nxt = div_r + 2'h1;
  end

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        `OFF_CTRL: prdata_nxt = ctrl_r;
        `OFF_PORT_EN: prdata_nxt = 32'(en_r);
        `OFF_PORT_FAULT: prdata_nxt = 32'(flt_r);
        `OFF_PORT_STATE: prdata_nxt = 32'(drive_r);
        `OFF_INT_STAT: prdata_nxt = 32'(ist_r);
        `OFF_INT_MASK: prdata_nxt = 32'(imsk_r);
        `OFF_QL: prdata_nxt = 32'(ql_r);
        `OFF_LED: prdata_nxt = {21'h0, led_out_fault, led_ref_d, led_ref_c, led_ref_b,
                                led_ref_a, led_status};
        default: begin
          for (int i = 0; i < NP; i++) begin
            if (paddr == `OFF_SQ_BASE + 12'(i / 8 * 4)) begin
              prdata_nxt[(i % 8)*4 +: 4] = sq_r[i];
            end
          end
        end
      endcase
    end else if (psel && penable && !pwrite) begin
      prdata_nxt = prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET;
      en_r <= `PORT_EN_RESET;
      flt_r <= '0;
      drive_r <= '0;
      ist_r <= 3'h0;
      imsk_r <= 3'h0;
      ql_r <= 4'h0;
      div_r <= 2'h0;
      last_sel_r <= 2'h0;
      last_sq_r <= '0;
      prdata <= 32'h0000_0000;
      for (int i = 0; i < NP; i++) sq_r[i] <= 4'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      en_r <= en_nxt;
      flt_r <= flt_nxt;
      drive_r <= drive_nxt;
      ist_r <= ist_nxt;
      imsk_r <= imsk_nxt;
      ql_r <= ql_nxt;
      div_r <= div_nxt;
      last_sel_r <= sel_r;
      last_sq_r <= sq_hit;
      prdata <= prdata_nxt;
      for (int i = 0; i < NP; i++) sq_r[i] <= sq_nxt[i];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // leds, outputs
  logic [31:0] blink_cnt_r, blink_cnt_nxt;
  logic blink_r, blink_nxt;
  logic [1:0] st_nxt, la_nxt, lb_nxt, lc_nxt, ld_nxt;
  logic [3:0] usable;
  always_comb begin
    blink_cnt_nxt = blink_cnt_r + 32'h1;
    blink_nxt = blink_r;
    if (blink_cnt_r >= 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_nxt = 32'h0;
      blink_nxt = !blink_r;
    end
    if (ctrl_r[`CTRL_FAIL]) st_nxt = led_amber;
    else if (ctrl_r[`CTRL_DISABLE] || ctrl_r[`CTRL_DOWNLOAD])
      st_nxt = blink_r ? led_green : led_off_type_v;
    else st_nxt = led_green;
    usable = pres_r & good_r;
    la_nxt = !usable[0] ? led_amber : (sel_r == ref_a) ? led_green : led_off_type_v;
    lb_nxt = !usable[1] ? led_amber : (sel_r == ref_b) ? led_green : led_off_type_v;
    lc_nxt = ctrl_r[`CTRL_BYPASS_IGN] ? led_off_type_v : !usable[2] ? led_amber :
             (sel_r == ref_c) ? led_green : led_off_type_v;
    // expansion reference, only in an expansion shelf
    ld_nxt = (ctrl_r[`CTRL_EXP_IGN] || !exp_r) ? led_off_type_v : !usable[3] ? led_amber :
             (sel_r == ref_d) ? led_green : led_off_type_v;
  end

  // status led registers one cycle after ctrl_r and blink_r, reference leds one cycle after synchronised inputs, fault led one cycle after flt_r
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
      led_status <= 2'h0;
      led_ref_a <= 2'h0;
      led_ref_b <= 2'h0;
      led_ref_c <= 2'h0;
      led_ref_d <= 2'h0;
      led_out_fault <= 1'b0;
      irq <= 1'b0;
      pll_ref_sel <= 2'h0;
      output_tip_line <= '0;
      output_ring_line <= '0;
      relay_closed <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      blink_cnt_r <= blink_cnt_nxt;
      blink_r <= blink_nxt;
      led_status <= st_nxt;
      led_ref_a <= la_nxt;
      led_ref_b <= lb_nxt;
      led_ref_c <= lc_nxt;
      led_ref_d <= ld_nxt;
      // any faulty port lights the fault led
      led_out_fault <= |flt_r;
      irq <= |(ist_r & imsk_r);
      pll_ref_sel <= (!exp_r && sel_r == ref_d) ? 2'(ref_a) : sel_r;
      // tip and ring complementary per driven port, both low when the port is not driven
      for (int i = 0; i < NP; i++) begin
        output_tip_line[i] <= drive_r[i] & div_r[1];
        output_ring_line[i] <= drive_r[i] & ~div_r[1];
      end
      relay_closed <= drive_r;
      pready <= psel && !penable;
      pslverr <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_fault_led_any: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> led_out_fault == |$past(flt_r)) else $error("fault led wrong");
  a_relay_follows: assert property (@(posedge pclk) disable iff (!presetn)
    !en_r[0] |-> ##2 !relay_closed[0]) else $error("relay closed while disabled");
  // all ports, so the random failing port is always covered
  a_nonred_keep: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_r[`CTRL_REDUNDANT] |=> drive_r == $past(en_r & ~sq_hit))
    else $error("failed port dropped");
  a_red_isolate: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r[`CTRL_REDUNDANT] && ctrl_r[`CTRL_ISOLATE]) |=> (drive_r & $past(flt_r)) == '0)
    else $error("isolation missed");
  a_squelch_on: assert property (@(posedge pclk) disable iff (!presetn)
    (sq_r[0] != 4'h0 && ql_r > sq_r[0]) |=> !drive_r[0]) else $error("no squelch");
  a_fault_flag: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> flt_r == $past(low_r)) else $error("fault flag lag");
  a_ref_a_amber: assert property (@(posedge pclk) disable iff (!presetn)
    !(pres_r[0] && good_r[0]) |=> led_ref_a == led_amber) else $error("ref a led");
  a_ref_b_green: assert property (@(posedge pclk) disable iff (!presetn)
    (pres_r[1] && good_r[1] && sel_r == ref_b) |=> led_ref_b == led_green)
    else $error("ref b led");
  a_bypass_ign: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r[`CTRL_BYPASS_IGN] |=> led_ref_c == led_off_type_v) else $error("bypass led");
  a_exp_absent: assert property (@(posedge pclk) disable iff (!presetn)
    !exp_r |=> led_ref_d == led_off_type_v) else $error("expansion led");
  a_status_fail: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r[`CTRL_FAIL] |=> led_status == led_amber) else $error("status led");
  c_squelch: cover property (@(posedge pclk) disable iff (!presetn) sq_hit[0]);
  c_fault: cover property (@(posedge pclk) disable iff (!presetn) led_out_fault);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule // clock_output_status_ctrl
`default_nettype wire

//--- clk_card_model.sv
// Purpose: far side model: clock cards, locked 8.192 MHz signal, level detectors
// Assumes: bench sets card presence, health, selection and detector flags
// Notes: behavioural only
`timescale 1ns/100ps
`default_nettype none
module clk_card_model (
  input wire logic [3:0] present_i,
  input wire logic [3:0] health_i,
  input wire logic [1:0] sel_i,
  input wire logic [19:0] low_i,
  output logic [3:0] ref_present,
  output logic [3:0] ref_good,
  output logic [1:0] ref_selected,
  output logic pll_clk_i,
  output logic [19:0] level_low
);
  // cards
  // an absent card can never report healthy
  assign ref_present = present_i;
  assign ref_good = present_i & health_i;
  assign ref_selected = sel_i;
  assign level_low = low_i;
  initial pll_clk_i = 1'b0;
  // locked signal, unrelated in phase to pclk
  always #61 pll_clk_i = ~pll_clk_i;
endmodule // clk_card_model
`default_nettype wire

//--- clock_output_status_ctrl_bench.sv
// Purpose: self-checking bench for clock_output_status_ctrl
// Assumes: zero-wait apb, pin inputs settle within eight cycles
// Notes: blink count shortened to 4
`timescale 1ns/100ps
`default_nettype none
module clock_output_status_ctrl_bench;
  import clkout_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, shelf = 1;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, seen_v, q[$];
  logic pready, pslverr, pll, fault_led, irq;
  logic [3:0] pres = 4'hf, hlth = 4'hf, rp, rg;
  logic [1:0] sel = 2'h0, rs, psel_out, led_status, la, lb, lc, ld;
  logic [19:0] low = 20'h0, ll, tip, ring, relay;
  int err_total = 0, n_tests = 0, seed = 32'h113c, np = 0, nt = 0, p, k;
  logic on_seen, off_seen;
  event got;
  always #5 pclk = ~pclk;
  clk_card_model cards (.present_i(pres), .health_i(hlth), .sel_i(sel), .low_i(low),
    .ref_present(rp), .ref_good(rg), .ref_selected(rs), .pll_clk_i(pll), .level_low(ll));
  clock_output_status_ctrl #(.BLINK_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_present(rp), .ref_good(rg),
    .ref_selected(rs), .expansion_shelf(shelf), .pll_clk_i(pll), .level_low(ll),
    .pll_ref_sel(psel_out), .output_tip_line(tip), .output_ring_line(ring),
    .relay_closed(relay), .led_status(led_status), .led_ref_a(la), .led_ref_b(lb),
    .led_ref_c(lc), .led_ref_d(ld), .led_out_fault(fault_led), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  // monitor: oldest note against each result
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) chk(prdata, q.pop_front());
  // no transfer, mapped or not, ends in an error
  always @(posedge pclk) if (psel && penable && pready === 1'b1) chk({31'h0, pslverr}, 32'h0);
  always @(got) chk(seen_v, q.pop_front());
  task pin(input logic [31:0] v, input logic [31:0] e);
    q.push_back(e);
    seen_v = v;
    ->got;
    #1;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      err_total++;
      end_of_test;
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(0, a, 32'h0);
    // let the monitor take this note before another is queued
    #1;
  endtask
  task settle;
    repeat (8) @(posedge pclk);
  endtask
  always @(posedge pll) np++;
  always @(posedge tip[0]) nt++;
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h000f_ffff);
    rd(12'h0fc, 32'h0);
    settle;
    pin(led_status, 32'h1);
    np = 0;
    nt = 0;
    repeat (400) @(posedge pclk);
    pin((nt * 4 - np <= 4 && np - nt * 4 <= 4), 32'h1);
    for (k = 0; k < 6; k++) begin
      #37;
      pin(tip, {20{tip[0]}});
      pin(ring, ~tip & 20'hf_ffff);
    end
    // green on selected, amber on missing neighbour
    for (k = 0; k < 4; k++) begin
      @(posedge pclk);
      sel <= k[1:0];
      pres <= ~(4'h1 << ((k + 1) % 4));
      settle;
      pin({la, lb, lc, ld}, {k == 0 ? 2'h1 : k == 3 ? 2'h2 : 2'h0,
        k == 1 ? 2'h1 : k == 0 ? 2'h2 : 2'h0, k == 2 ? 2'h1 : k == 1 ? 2'h2 : 2'h0,
        k == 3 ? 2'h1 : k == 2 ? 2'h2 : 2'h0});
      pin(psel_out, k);
    end
    // outside an expansion shelf the fourth reference is not usable
    @(posedge pclk);
    shelf <= 1'b0;
    settle;
    pin(ld, 32'h0);
    pin(psel_out, 32'h0);
    // ignored bypass and expansion stay dark even when missing
    @(posedge pclk);
    shelf <= 1'b1;
    sel <= 2'h0;
    pres <= 4'h3;
    bus(1, 12'h000, 32'h60);
    settle;
    pin({la, lb, lc, ld}, 32'h40);
    bus(1, 12'h000, 32'h4);
    settle;
    pin(led_status, 32'h2);
    bus(1, 12'h000, 32'h1);
    on_seen = 0;
    off_seen = 0;
    repeat (12) begin
      @(posedge pclk);
      on_seen |= (led_status === 2'h1);
      off_seen |= (led_status === 2'h0);
    end
    pin(on_seen & off_seen, 32'h1);
    bus(1, 12'h000, 32'h0);
    bus(1, 12'h004, 32'h6);
    settle;
    pin(relay, 32'h6);
    pin(tip & 20'hf_fff9, 32'h0);
    bus(1, 12'h004, 32'hf_ffff);
    bus(1, 12'h010, 32'h7);
    bus(1, 12'h014, 32'h1);
    // random failing port
    p = {$random(seed)} % 20;
    @(posedge pclk);
    low <= 20'h1 << p;
    settle;
    pin(fault_led, 32'h1);
    rd(12'h008, 32'h1 << p);
    pin(irq, 32'h1);
    pin(relay, 32'hf_ffff);
    bus(1, 12'h000, 32'h8);
    settle;
    pin(relay, 32'hf_ffff);
    bus(1, 12'h000, 32'h18);
    settle;
    pin(relay, ~(32'h1 << p) & 32'hf_ffff);
    bus(1, 12'h014, 32'h0);
    settle;
    pin(irq, 32'h0);
    bus(1, 12'h000, 32'h0);
    @(posedge pclk);
    low <= 20'h0;
    settle;
    bus(1, 12'h010, 32'h1);
    rd(12'h010, 32'h0);
    pin(fault_led, 32'h0);
    // port 0 threshold 3, port 1 threshold zero
    bus(1, 12'h020, 32'h3);
    bus(1, 12'h018, 32'h3);
    settle;
    pin(relay, 32'hf_ffff);
    bus(1, 12'h018, 32'h4);
    settle;
    pin(relay, 32'hf_fffe);
    end_of_test;
  end
endmodule // clock_output_status_ctrl_bench
`default_nettype wire
